// ---- fast_timer_pwm_unit_tb.sv ----
`timescale 1ns/1ns
`include "fpw_consts.vh"

module fast_timer_pwm_unit_tb;
    logic        clk_sys, nrst, ce, fast_peripheral_clk, pll_locked, global_irq_en, wr, rd, pend;
    logic [7:0]  addr, wdata, v;
    logic [1:0]  fdiv;
    logic [31:0] lf;
    logic [7:0]  expq[$];
    wire  [7:0]  rdata;
    wire         out_a, out_a_oe, out_a_n, out_a_n_oe, out_b, out_b_oe, out_b_n, out_b_n_oe;
    wire         irq_overflow, irq_match_a, irq_match_b;
    int          failures, n_checks, ha, hb, ra, rb;
    // {addr, expected}; 8'h10 is unmapped
    logic [15:0] rst_tab [10] = '{16'h2701, 16'h2b00, 16'h2c00, 16'h2dff, 16'h2e00,
                                 16'h2f00, 16'h3000, 16'h3800, 16'h3900, 16'h1000};
    // {addr, writable mask, fixed ones}
    logic [23:0] rb_tab [7] = '{24'h270401, 24'h2bff00, 24'h2c7000, 24'h2dff00,
                               24'h2eff00, 24'h30f000, 24'h396400};
    // {pll, timer ctrl, compare, window, high cycles (ff = any), rises}; top is 9
    logic [47:0] pw_tab [15] = '{48'h005103140602, 48'h005100140000, 48'h005109141400,
        48'h006100140000, 48'h006109141400, 48'h007100141400, 48'h007109140000,
        48'h007103140e02, 48'h004103000000, 48'h005203280c02, 48'h005303501802,
        48'h005403a03002, 48'h00500328ff00, 48'h009103281402, 48'h045103501802};

    fpw_timer i_dut (
        .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .fast_peripheral_clk(fast_peripheral_clk),
        .pll_locked(pll_locked), .global_irq_en(global_irq_en), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .out_a(out_a), .out_a_oe(out_a_oe), .out_a_n(out_a_n),
        .out_a_n_oe(out_a_n_oe), .out_b(out_b), .out_b_oe(out_b_oe), .out_b_n(out_b_n),
        .out_b_n_oe(out_b_n_oe), .irq_overflow(irq_overflow), .irq_match_a(irq_match_a),
        .irq_match_b(irq_match_b));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // fast source kept below half the system rate, since the design samples it
    always @(posedge clk_sys) begin
        fdiv <= fdiv + 2'h1;
        fast_peripheral_clk <= fdiv[1];
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task rd_exp(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
    endtask

    // counts high cycles and rising edges over exactly n cycles
    task samp(input int n);
        logic pa, pb;
        {ha, hb, ra, rb} = 128'h0;
        @(negedge clk_sys);
        pa = out_a;
        pb = out_b;
        repeat (n) begin
            @(negedge clk_sys);
            ha += out_a;
            hb += out_b;
            ra += out_a & !pa;
            rb += out_b & !pb;
            pa = out_a;
            pb = out_b;
        end
    endtask

    // read answers are taken half a cycle after they land, clear of the edge
    always @(negedge clk_sys) begin
        if (pend)
            chk({8'h00, rdata}, {8'h00, expq.pop_front()});
        pend = rd;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        wrap_up();
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        fast_peripheral_clk = 1'b0;
        pll_locked = 1'b1;
        global_irq_en = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        {failures, n_checks} = 64'h0;
        pend = 1'b0;
        fdiv = 2'h0;
        lf = 32'h67c0;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        foreach (rst_tab[i]) rd_exp(rst_tab[i][15:8], rst_tab[i][7:0]);
        repeat (3) foreach (rb_tab[i]) begin
            lf = lfsr(lf);
            v = lf[7:0] & rb_tab[i][15:8];
            wr_reg(rb_tab[i][23:16], v);
            rd_exp(rb_tab[i][23:16], v | rb_tab[i][7:0]);
        end
        wr_reg(8'h27, 8'h00);
        wr_reg(8'h2b, 8'h80);
        wr_reg(8'h2e, 8'h05);
        wr_reg(8'h2d, 8'hff);
        wr_reg(8'h2c, 8'h00);
        wr_reg(8'h38, 8'h64);
        wr_reg(8'h39, 8'h04);
        global_irq_en <= 1'b1;
        wr_reg(8'h30, 8'h01);
        repeat (300) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(16'(irq_overflow), 16'h1);
        chk(16'(irq_match_a), 16'h0);
        chk(16'(irq_match_b), 16'h0);
        wr_reg(8'h30, 8'h00);
        rd_exp(8'h38, 8'h64);
        wr_reg(8'h38, 8'h64);
        rd_exp(8'h38, 8'h00);
        @(negedge clk_sys);
        chk(16'(irq_overflow), 16'h0);
        wr_reg(8'h2d, 8'h09);
        // overflow run left the counter above top; pwm would only reach top after an ff wrap
        wr_reg(8'h2f, 8'h00);
        foreach (pw_tab[i]) begin
            wr_reg(8'h27, pw_tab[i][47:40]);
            wr_reg(8'h2e, pw_tab[i][31:24]);
            wr_reg(8'h2b, pw_tab[i][31:24]);
            wr_reg(8'h30, pw_tab[i][39:32]);
            wr_reg(8'h2c, pw_tab[i][39:32] & 8'h70);
            repeat (pw_tab[i][23:16] + 30) @(posedge clk_sys);
            samp(pw_tab[i][23:16]);
            chk(16'(out_a_oe), 16'(pw_tab[i][37:36] != 2'h0));
            chk(16'(out_b_oe), 16'(pw_tab[i][37:36] != 2'h0));
            chk(16'(out_a_n_oe), 16'(pw_tab[i][38] && pw_tab[i][37:36] == 2'h1));
            chk(16'(out_b_n_oe), 16'(pw_tab[i][38] && pw_tab[i][37:36] == 2'h1));
            if (pw_tab[i][23:16] != 8'h00) begin
                chk(ra[15:0], 16'(pw_tab[i][7:0]));
                chk(rb[15:0], 16'(pw_tab[i][7:0]));
                if (pw_tab[i][15:8] != 8'hff) begin
                    chk(ha[15:0], 16'(pw_tab[i][15:8]));
                    chk(hb[15:0], 16'(pw_tab[i][15:8]));
                end
            end
        end
        repeat (4) @(posedge clk_sys);
        wrap_up();
    end
endmodule // fast_timer_pwm_unit_tb

// ---- fpw_consts.vh ----
`ifndef FPW_CONSTS_VH
`define FPW_CONSTS_VH

// register offsets on the 8-bit register port
`define FPW_OFS_PLL_CTRL_STATUS 8'h27
`define FPW_OFS_COMPARE_B       8'h2b
`define FPW_OFS_GEN_TIMER_CTRL  8'h2c
`define FPW_OFS_TOP_COMPARE     8'h2d
`define FPW_OFS_COMPARE_A       8'h2e
`define FPW_OFS_COUNT           8'h2f
`define FPW_OFS_TIMER_CTRL      8'h30
`define FPW_OFS_FLAG            8'h38
`define FPW_OFS_IRQ_MASK        8'h39

// timer_ctrl fields
`define FPW_TC_CLEAR_ON_TOP     7
`define FPW_TC_PWM_A_EN         6
`define FPW_TC_MODE_A_HI        5
`define FPW_TC_MODE_A_LO        4
`define FPW_TC_PRESCALE_HI      3
`define FPW_TC_PRESCALE_LO      0

// general_timer_ctrl fields
`define FPW_GC_PWM_B_EN         6
`define FPW_GC_MODE_B_HI        5
`define FPW_GC_MODE_B_LO        4
`define FPW_GC_FORCE_B          3
`define FPW_GC_FORCE_A          2
`define FPW_GC_PRESCALER_CLEAR  1
`define FPW_GC_STORED_MASK      8'h70

// flag_reg and irq_mask_reg fields
`define FPW_FL_MATCH_A          6
`define FPW_FL_MATCH_B          5
`define FPW_FL_OVERFLOW         2
`define FPW_FL_MASK             8'h64

// pll_ctrl_status fields
`define FPW_PLL_ASYNC_CLK_EN    2
`define FPW_PLL_LOCKED          0

// reset values
`define FPW_RST_BYTE            8'h00
`define FPW_RST_TOP             8'hff

// output modes
`define FPW_MODE_OFF            2'h0
`define FPW_MODE_TOGGLE         2'h1
`define FPW_MODE_CLEAR          2'h2
`define FPW_MODE_SET            2'h3

// counter landmarks
`define FPW_CNT_ZERO            8'h00
`define FPW_CNT_FULL            8'hff

// clock figures
`define FPW_SYS_CLK_MHZ         100
`define FPW_PCK_FAST_MHZ        64
`define FPW_PCK_SLOW_MHZ        32
`define FPW_PLL_SETTLE_US       100
`define FPW_PRESCALE_STAGES     14

`endif

// ---- fpw_prescaler.v ----
`timescale 1ns/1ns
`include "fpw_consts.vh"

module fpw_prescaler #(
    parameter STAGES = `FPW_PRESCALE_STAGES
) (
    input  wire       clk_sys,
    input  wire       nrst,
    input  wire       ce,
    input  wire       src_tick,
    input  wire       clear,
    input  wire [3:0] sel,
    output reg        tick_out
);
    reg  [STAGES-1:0] div_reg;
    reg  [STAGES-1:0] tap_mask;
    reg               tap_hit;
    integer           i;

    // divide by 2^(sel-1): fire when the low sel-1 bits are all ones
    always @* begin
        tap_mask = {STAGES{1'b0}};
        for (i = 0; i < STAGES; i = i + 1) begin
            tap_mask[i] = ((i + 1) < sel);
        end
        tap_hit = &(div_reg | ~tap_mask);
    end

    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            div_reg  <= {STAGES{1'b0}};
            tick_out <= 1'b0;
        end else if (ce) begin
            if (clear) begin
                div_reg  <= {STAGES{1'b0}}; // R3
                tick_out <= 1'b0;
            end else begin
                if (src_tick) begin
                    div_reg <= div_reg + {{(STAGES-1){1'b0}}, 1'b1};
                end
                tick_out <= src_tick && (sel != 4'h0) && tap_hit; // R2
            end
        end
    end
endmodule // fpw_prescaler

// ---- fpw_timer.v ----
// How it works
// R1: async_clk_enable picks the fast peripheral clock, otherwise system clock paces prescaler.
// R2: prescaler stops at select zero, else divides by powers of two up to 16384.
// R3: writing one to prescaler_clear restarts the division chain.
// R4: fast peripheral clock is 64 MHz, or 32 MHz in low speed mode.
// R5: control and compare read back at once; count and flags lag.
// R6: software values pass through a sync stage before steering the counter.
// R7: system clock must stay below a third of the fast clock; the code instead needs the fast clock below half of clk_sys.
// R8: all compares run; compare A drives out_a, B drives out_b, both flag.
// R9: top_compare_reg holds the 8-bit top where the counter clears.
// R10: overflow on FF to 00 wrap; in pwm also on top to 00.
// R11: complement outputs are disconnected in normal mode.
// R12: pwm counter runs 00 up to top then restarts at 00.
// R13: in pwm a top match sets overflow after a sync delay.
// R14: pwm gives two 8-bit channels, each true and inverted.
// R15: complement pairs switch together with no dead time.
// R16: pwm modes: off, clear-set with complement, clear-set, set-clear.
// R17: pwm compare writes wait in a buffer until the counter hits top.
// R18: compare reads return the buffer, so latest write reads back.
// R19: compare at 00 or top gives static outputs per mode.
// R20: interrupt requested when flag, its mask bit and global enable are set.
// R21: pwm period is top plus one timer ticks.
// R22: software settles the pll 100 us and waits for lock before async.
// R23: clear_on_top returns counter to 00 after a top match.
// R24: pwm enable puts a channel in pwm and clears counter at top.
// R25: normal modes: off, toggle, clear, set on match.
`timescale 1ns/1ns
`include "fpw_consts.vh"

module fpw_timer #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          clk_sys,
    input  wire          nrst,
    input  wire          ce,
    input  wire          fast_peripheral_clk,
    input  wire          pll_locked,
    input  wire          global_irq_en,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    input  wire          wr,
    input  wire          rd,
    output wire [DW-1:0] rdata,
    output wire          out_a,
    output wire          out_a_oe,
    output wire          out_a_n,
    output wire          out_a_n_oe,
    output wire          out_b,
    output wire          out_b_oe,
    output wire          out_b_n,
    output wire          out_b_n_oe,
    output wire          irq_overflow,
    output wire          irq_match_a,
    output wire          irq_match_b
);
    // software-side registers
    reg  [7:0] timer_ctrl_reg;
    reg  [7:0] general_timer_ctrl_reg;
    reg  [7:0] top_compare_reg;
    reg  [7:0] irq_mask_reg;
    reg  [7:0] flag_reg;
    reg        async_clk_enable_reg;
    reg  [7:0] cmp_buf_reg [0:1];
    reg  [7:0] rdata_reg;
    reg  [2:0] irq_reg;

    // counter-side copies after the sync stage
    reg  [7:0] ctrl_s_reg;
    reg  [7:0] gen_s_reg;
    reg  [7:0] top_s_reg;
    reg  [7:0] buf_s_reg [0:1];
    reg        async_s_reg;
    reg  [1:0] force_s_reg;
    reg        psc_clear_s_reg;
    reg        cnt_wr_s_reg;
    reg  [7:0] cnt_wdata_s_reg;

    reg  [7:0] count_reg;
    reg  [7:0] count_rd_reg;
    reg  [7:0] cmp_act_reg [0:1];
    reg  [2:0] event_reg;
    reg        fclk_d_reg;

    wire       wr_ctrl  = wr && (addr == `FPW_OFS_TIMER_CTRL);
    wire       wr_gen   = wr && (addr == `FPW_OFS_GEN_TIMER_CTRL);
    wire       wr_cmp_a = wr && (addr == `FPW_OFS_COMPARE_A);
    wire       wr_cmp_b = wr && (addr == `FPW_OFS_COMPARE_B);
    wire       wr_top   = wr && (addr == `FPW_OFS_TOP_COMPARE);
    wire       wr_cnt   = wr && (addr == `FPW_OFS_COUNT);
    wire       wr_flag  = wr && (addr == `FPW_OFS_FLAG);
    wire       wr_mask  = wr && (addr == `FPW_OFS_IRQ_MASK);
    wire       wr_pll   = wr && (addr == `FPW_OFS_PLL_CTRL_STATUS);

    wire [1:0] pwm_en   = {gen_s_reg[`FPW_GC_PWM_B_EN], ctrl_s_reg[`FPW_TC_PWM_A_EN]};
    wire [3:0] mode_sel = {gen_s_reg[`FPW_GC_MODE_B_HI:`FPW_GC_MODE_B_LO],
                           ctrl_s_reg[`FPW_TC_MODE_A_HI:`FPW_TC_MODE_A_LO]};
    wire       pwm_any  = |pwm_en;
    wire       clr_top  = ctrl_s_reg[`FPW_TC_CLEAR_ON_TOP] | pwm_any; // R23 R24

    // sampling the fast clock caps the usable async rate at half of clk_sys
    wire       fclk_rise = fast_peripheral_clk & ~fclk_d_reg;
    wire       src_tick  = async_s_reg ? fclk_rise : 1'b1; // R1 R4
    wire       tmr_tick;

    wire       top_hit   = (count_reg == top_s_reg); // R9
    wire       full_hit  = (count_reg == `FPW_CNT_FULL);
    wire       wrap      = tmr_tick && ((clr_top && top_hit) || full_hit);
    wire       ovf_event = tmr_tick && (full_hit || (pwm_any && top_hit)); // R10 R13
    wire [1:0] match;
    wire [1:0] ch_out;
    wire [1:0] ch_out_n;
    wire [1:0] ch_oe;
    wire [1:0] ch_oe_n;

    fpw_prescaler #(
        .STAGES   (`FPW_PRESCALE_STAGES)
    ) u_prescaler (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .ce       (ce),
        .src_tick (src_tick),
        .clear    (psc_clear_s_reg),
        .sel      (ctrl_s_reg[`FPW_TC_PRESCALE_HI:`FPW_TC_PRESCALE_LO]),
        .tick_out (tmr_tick)
    );

    // software register writes
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            timer_ctrl_reg         <= `FPW_RST_BYTE;
            general_timer_ctrl_reg <= `FPW_RST_BYTE;
            top_compare_reg        <= `FPW_RST_TOP;
            irq_mask_reg           <= `FPW_RST_BYTE;
            async_clk_enable_reg   <= 1'b0;
            cmp_buf_reg[0]         <= `FPW_RST_BYTE;
            cmp_buf_reg[1]         <= `FPW_RST_BYTE;
        end else if (ce) begin
            if (wr_ctrl) begin
                timer_ctrl_reg <= wdata;
            end
            if (wr_gen) begin
                general_timer_ctrl_reg <= wdata & `FPW_GC_STORED_MASK;
            end
            if (wr_top) begin
                top_compare_reg <= wdata;
            end
            if (wr_mask) begin
                irq_mask_reg <= wdata & `FPW_FL_MASK;
            end
            if (wr_pll) begin
                async_clk_enable_reg <= wdata[`FPW_PLL_ASYNC_CLK_EN]; // R22
            end
            if (wr_cmp_a) begin
                cmp_buf_reg[0] <= wdata; // R17
            end
            if (wr_cmp_b) begin
                cmp_buf_reg[1] <= wdata; // R17
            end
        end
    end

    // one sync stage between software writes and the counter
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_s_reg      <= `FPW_RST_BYTE;
            gen_s_reg       <= `FPW_RST_BYTE;
            top_s_reg       <= `FPW_RST_TOP;
            buf_s_reg[0]    <= `FPW_RST_BYTE;
            buf_s_reg[1]    <= `FPW_RST_BYTE;
            async_s_reg     <= 1'b0;
            force_s_reg     <= 2'h0;
            psc_clear_s_reg <= 1'b0;
            cnt_wr_s_reg    <= 1'b0;
            cnt_wdata_s_reg <= `FPW_RST_BYTE;
            fclk_d_reg      <= 1'b0;
        end else if (ce) begin
            ctrl_s_reg      <= timer_ctrl_reg; // R6
            gen_s_reg       <= general_timer_ctrl_reg; // R6
            top_s_reg       <= top_compare_reg; // R6
            buf_s_reg[0]    <= cmp_buf_reg[0]; // R6
            buf_s_reg[1]    <= cmp_buf_reg[1]; // R6
            async_s_reg     <= async_clk_enable_reg; // R6
            force_s_reg     <= {wr_gen && wdata[`FPW_GC_FORCE_B], wr_gen && wdata[`FPW_GC_FORCE_A]};
            psc_clear_s_reg <= wr_gen && wdata[`FPW_GC_PRESCALER_CLEAR]; // R3
            cnt_wr_s_reg    <= wr_cnt;
            cnt_wdata_s_reg <= wdata;
            fclk_d_reg      <= fast_peripheral_clk;
        end
    end

    // counter, active compares and event pipeline
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            count_reg      <= `FPW_CNT_ZERO;
            count_rd_reg   <= `FPW_CNT_ZERO;
            cmp_act_reg[0] <= `FPW_RST_BYTE;
            cmp_act_reg[1] <= `FPW_RST_BYTE;
            event_reg      <= 3'h0;
        end else if (ce) begin
            if (cnt_wr_s_reg) begin
                count_reg <= cnt_wdata_s_reg;
            end else if (wrap) begin
                count_reg <= `FPW_CNT_ZERO; // R12 R21 R23
            end else if (tmr_tick) begin
                count_reg <= count_reg + 8'h01;
            end
            count_rd_reg <= count_reg; // R5
            // in pwm the new compare only lands at top, so a period never sees two values
            if (!pwm_en[0] || (tmr_tick && top_hit)) begin
                cmp_act_reg[0] <= buf_s_reg[0]; // R17
            end
            if (!pwm_en[1] || (tmr_tick && top_hit)) begin
                cmp_act_reg[1] <= buf_s_reg[1]; // R17
            end
            event_reg <= {ovf_event, tmr_tick && match[1], tmr_tick && match[0]}; // R13
        end
    end

    // flags: hardware set wins over a write-one clear
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flag_reg <= `FPW_RST_BYTE;
        end else if (ce) begin
            flag_reg[`FPW_FL_MATCH_A]  <= event_reg[0] |
                                          (flag_reg[`FPW_FL_MATCH_A] & ~(wr_flag & wdata[`FPW_FL_MATCH_A])); // R8
            flag_reg[`FPW_FL_MATCH_B]  <= event_reg[1] |
                                          (flag_reg[`FPW_FL_MATCH_B] & ~(wr_flag & wdata[`FPW_FL_MATCH_B])); // R8
            flag_reg[`FPW_FL_OVERFLOW] <= event_reg[2] |
                                          (flag_reg[`FPW_FL_OVERFLOW] & ~(wr_flag & wdata[`FPW_FL_OVERFLOW])); // R10
        end
    end

    // interrupt requests
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 3'h0;
        end else if (ce) begin
            irq_reg[0] <= global_irq_en & flag_reg[`FPW_FL_OVERFLOW] & irq_mask_reg[`FPW_FL_OVERFLOW]; // R20
            irq_reg[1] <= global_irq_en & flag_reg[`FPW_FL_MATCH_A] & irq_mask_reg[`FPW_FL_MATCH_A]; // R20
            irq_reg[2] <= global_irq_en & flag_reg[`FPW_FL_MATCH_B] & irq_mask_reg[`FPW_FL_MATCH_B]; // R20
        end
    end

    // read port, data valid the cycle after rd only
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= `FPW_RST_BYTE;
        end else if (ce) begin
            if (rd) begin
                case (addr)
                    `FPW_OFS_TIMER_CTRL:      rdata_reg <= timer_ctrl_reg; // R5
                    `FPW_OFS_GEN_TIMER_CTRL:  rdata_reg <= general_timer_ctrl_reg; // R5
                    `FPW_OFS_TOP_COMPARE:     rdata_reg <= top_compare_reg; // R5
                    `FPW_OFS_COMPARE_A:       rdata_reg <= cmp_buf_reg[0]; // R18
                    `FPW_OFS_COMPARE_B:       rdata_reg <= cmp_buf_reg[1]; // R18
                    `FPW_OFS_COUNT:           rdata_reg <= count_rd_reg; // R5
                    `FPW_OFS_FLAG:            rdata_reg <= flag_reg; // R5
                    `FPW_OFS_IRQ_MASK:        rdata_reg <= irq_mask_reg;
                    `FPW_OFS_PLL_CTRL_STATUS: rdata_reg <= {5'h00, async_clk_enable_reg, 1'b0, pll_locked};
                    default:                  rdata_reg <= `FPW_RST_BYTE;
                endcase
            end else begin
                rdata_reg <= `FPW_RST_BYTE;
            end
        end
    end

    // output channels: index 0 is A, index 1 is B
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            reg        q_reg;
            reg        qn_reg;
            reg        oe_reg;
            reg        oen_reg;
            reg        q_next;
            wire [1:0] mode  = mode_sel[2*g+1:2*g];
            wire       at_top = (cmp_act_reg[g] == top_s_reg);

            assign match[g] = (count_reg == cmp_act_reg[g]); // R8

            always @* begin
                q_next = q_reg;
                if (pwm_en[g]) begin
                    if (tmr_tick) begin
                        // compare at top is suppressed so the level stays static
                        if (match[g] && !at_top) begin
                            q_next = (mode == `FPW_MODE_SET); // R16 R19
                        end else if (count_reg == `FPW_CNT_ZERO) begin
                            q_next = (mode != `FPW_MODE_SET); // R16 R19
                        end
                    end
                end else if (force_s_reg[g] || (tmr_tick && match[g])) begin
                    case (mode)
                        `FPW_MODE_TOGGLE: q_next = ~q_reg; // R25
                        `FPW_MODE_CLEAR:  q_next = 1'b0; // R25
                        `FPW_MODE_SET:    q_next = 1'b1; // R25
                        default:          q_next = q_reg;
                    endcase
                end
            end

            always @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    q_reg   <= 1'b0;
                    qn_reg  <= 1'b1; // pair stays complementary out of reset
                    oe_reg  <= 1'b0;
                    oen_reg <= 1'b0;
                end else if (ce) begin
                    q_reg   <= q_next;
                    qn_reg  <= ~q_next; // R14 R15
                    oe_reg  <= (mode != `FPW_MODE_OFF); // R16 R25
                    oen_reg <= pwm_en[g] && (mode == `FPW_MODE_TOGGLE); // R11 R16
                end
            end

            assign ch_out[g]   = q_reg;
            assign ch_out_n[g] = qn_reg;
            assign ch_oe[g]    = oe_reg;
            assign ch_oe_n[g]  = oen_reg;
        end
    endgenerate

    assign rdata        = rdata_reg;
    assign out_a        = ch_out[0];
    assign out_a_oe     = ch_oe[0];
    assign out_a_n      = ch_out_n[0];
    assign out_a_n_oe   = ch_oe_n[0];
    assign out_b        = ch_out[1];
    assign out_b_oe     = ch_oe[1];
    assign out_b_n      = ch_out_n[1];
    assign out_b_n_oe   = ch_oe_n[1];
    assign irq_overflow = irq_reg[0];
    assign irq_match_a  = irq_reg[1];
    assign irq_match_b  = irq_reg[2];
endmodule // fpw_timer

// ---- fpw_timer_monitor.sv ----
`timescale 1ns/1ns
`include "fpw_consts.vh"

module fpw_timer_monitor #(
    parameter AW = 8,
    parameter DW = 8
) (
    input wire          clk_sys,
    input wire          nrst,
    input wire          ce,
    input wire          fast_peripheral_clk,
    input wire          pll_locked,
    input wire          global_irq_en,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wdata,
    input wire          wr,
    input wire          rd,
    input wire [DW-1:0] rdata,
    input wire          out_a,
    input wire          out_a_oe,
    input wire          out_a_n,
    input wire          out_a_n_oe,
    input wire          out_b,
    input wire          out_b_oe,
    input wire          out_b_n,
    input wire          out_b_n_oe,
    input wire          irq_overflow,
    input wire          irq_match_a,
    input wire          irq_match_b
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_rd_idle_zero: assert property (
        ce && !rd |=> rdata == 8'h00)
        else $error("read data not zero outside the answer cycle");
    a_ctrl_readback: assert property (
        (wr && addr == `FPW_OFS_TIMER_CTRL) ##1 !wr ##1 (rd && addr == `FPW_OFS_TIMER_CTRL)
        |=> rdata == $past(wdata, 3))
        else $error("timer control read back differs from written value");
    a_cmpa_readback: assert property (
        (wr && addr == `FPW_OFS_COMPARE_A) ##1 !wr ##1 (rd && addr == `FPW_OFS_COMPARE_A)
        |=> rdata == $past(wdata, 3))
        else $error("compare a read back differs from latest write");
    a_cmpb_readback: assert property (
        (wr && addr == `FPW_OFS_COMPARE_B) ##1 !wr ##1 (rd && addr == `FPW_OFS_COMPARE_B)
        |=> rdata == $past(wdata, 3))
        else $error("compare b read back differs from latest write");
    a_irq_global_gate: assert property (
        ce && !global_irq_en |=> !irq_overflow && !irq_match_a && !irq_match_b)
        else $error("interrupt raised with global enable low");
    a_pair_a_comp: assert property (
        out_a_n == !out_a)
        else $error("channel a pair not complementary");
    a_pair_b_comp: assert property (
        out_b_n == !out_b)
        else $error("channel b pair not complementary");
    a_inv_a_conn: assert property (
        out_a_n_oe |-> out_a_oe)
        else $error("inverted a driven while true a disconnected");
    a_inv_b_conn: assert property (
        out_b_n_oe |-> out_b_oe)
        else $error("inverted b driven while true b disconnected");
endmodule // fpw_timer_monitor

bind fpw_timer fpw_timer_monitor #(.AW(AW), .DW(DW)) i_mon (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .fast_peripheral_clk(fast_peripheral_clk),
    .pll_locked(pll_locked), .global_irq_en(global_irq_en), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .out_a(out_a), .out_a_oe(out_a_oe), .out_a_n(out_a_n),
    .out_a_n_oe(out_a_n_oe), .out_b(out_b), .out_b_oe(out_b_oe), .out_b_n(out_b_n),
    .out_b_n_oe(out_b_n_oe), .irq_overflow(irq_overflow), .irq_match_a(irq_match_a),
    .irq_match_b(irq_match_b));
